// >>> hdl/tvs_pkg.sv
// How it works
// [RULE_01] With no start address programmed, a run begins at address zero.
// [RULE_02] Software keeps a start address inside the range set by the page size.
// [RULE_03] Outer count 1..4096; at outer end with count left, branch to zero.
// [RULE_04] Outer end is the last loaded word unless programmed explicitly.
// [RULE_05] Without an outer loop programmed, the region runs once then stops.
// [RULE_06] Inner loop: count, start, end; at end return to start until used.
// [RULE_07] Inner settings persist across runs; count defaults to one, which disables it.
// [RULE_08] Software writes inner start and end together, count may change alone.
// [RULE_09] Ignore by address masks fails until that vector executes, then strobes.
// [RULE_10] Ignore count 0..8388607 masks fails for that many cycles after start.
// [RULE_11] Ignore by address or by count: the last one written wins.
// [RULE_12] Sticky capture clears fails at start, accumulates, and never stops early.
// [RULE_13] Without sticky capture the fail result is cleared before each strobe.
// [RULE_14] Single pass runs from start address to test end, honouring loops.
// [RULE_15] Reaching the page wrap location before test end continues at zero.
// [RULE_16] Page size selects wrap 1023, 2047 or 4095 and chaining permissions.
// [RULE_17] Free-running mode loops forever from outer end to zero until exit.
// [RULE_18] Free-running: past inner start strobing stops, inner end branches back.
// [RULE_19] Host may rewrite memory outside the inner loop while it circulates.
// [RULE_20] After exit request, first inner end arrival falls through to end plus one.
// [RULE_21] On exit at shared end, stop if outer count is zero, else branch.
// [RULE_22] Fail masking works the same in single-pass and free-running modes.
// [RULE_23] Busy while running; done with pass or fail outcome at termination.
package tvs_pkg;
   localparam int AW = 12;
   localparam int NPIN = 8;
   localparam int WW = 3 * NPIN;
   localparam int CW = 13;
   localparam int IW = 23;
   // Word index of each register; byte address is four times the index.
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_START = 4'h1;
   localparam logic [3:0] IDX_OUTER = 4'h2;
   localparam logic [3:0] IDX_INNER_CNT = 4'h3;
   localparam logic [3:0] IDX_INNER_BND = 4'h4;
   localparam logic [3:0] IDX_IGN_ADDR = 4'h5;
   localparam logic [3:0] IDX_IGN_CNT = 4'h6;
   localparam logic [3:0] IDX_PAGE = 4'h7;
   localparam logic [3:0] IDX_STATUS = 4'h8;
   localparam logic [3:0] IDX_FAIL = 4'h9;
   localparam logic [3:0] IDX_MEM_ADDR = 4'ha;
   localparam logic [3:0] IDX_MEM_DATA = 4'hb;
   // Control register bit positions.
   localparam int CTRL_START = 0;
   localparam int CTRL_EXIT = 1;
   localparam int CTRL_FREE = 2;
   localparam int CTRL_IGN = 3;
   localparam int CTRL_STICKY = 4;
   // Field position of the high half in count/end and start/end registers.
   localparam int HI_POS = 16;
   // Reset values.
   localparam logic [CW-1:0] RST_COUNT = 13'h0001;
   localparam logic [CW-1:0] RST_PAGE = 13'h1000;
   // Page size limits and their wrap locations.
   localparam logic [CW-1:0] PAGE_1K = 13'h0400;
   localparam logic [CW-1:0] PAGE_2K = 13'h0800;
   localparam logic [AW-1:0] WRAP_1K = 12'h3ff;
   localparam logic [AW-1:0] WRAP_2K = 12'h7ff;
   localparam logic [AW-1:0] WRAP_4K = 12'hfff;
   // Cycles from the last issued vector to its comparison.
   localparam logic [1:0] DRAIN_CYC = 2'h3;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN} tvs_state_e;
endpackage

// >>> hdl/tvs_pattern_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Simple dual-port pattern memory: the bus writes while the sequencer reads,
// so a free-running loop keeps playing while the host reloads other words.
module tvs_pattern_mem
   import tvs_pkg::*;
(
   input  wire logic          hclk,   // clock
   input  wire logic          we,     // write strobe
   input  wire logic [AW-1:0] waddr,  // write address
   input  wire logic [WW-1:0] wdata,  // write data
   input  wire logic [AW-1:0] raddr,  // read address
   output logic      [WW-1:0] rdata   // registered read data
);
   logic [WW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge hclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// >>> hdl/tvs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tvs_sequencer
   import tvs_pkg::*;
(
   input  wire logic            hclk,       // clock, 20 MHz
   input  wire logic            hresetn,    // async reset, active low
   input  wire logic            hsel,       // slave select
   input  wire logic [31:0]     haddr,      // byte address
   input  wire logic [1:0]      htrans,     // transfer type
   input  wire logic            hwrite,     // write when high
   input  wire logic [2:0]      hsize,      // transfer size
   input  wire logic [31:0]     hwdata,     // write data
   input  wire logic            hready,     // bus ready
   output logic                 hreadyout,  // always ready
   output logic                 hresp,      // always OKAY
   output logic [31:0]          hrdata,     // read data
   output logic [NPIN-1:0]      vec_drive,  // vector to the device under test
   output logic                 vec_valid,  // vector on vec_drive is live
   input  wire logic [NPIN-1:0] dut_resp,   // device response pins
   output logic                 busy,       // test running
   output logic                 done,       // test terminated
   output logic                 failed      // outcome of last test
);
   typedef struct packed {
      logic            wr_pend;
      logic [3:0]      wr_idx;
      logic [31:0]     rdata;
      logic            free_cfg;
      logic            ign_opt;
      logic            sticky;
      logic [AW-1:0]   start_addr;
      logic            start_set;
      logic [CW-1:0]   outer_cnt;
      logic [AW-1:0]   outer_end_cfg;
      logic            outer_set;
      logic [CW-1:0]   inner_cnt;
      logic [AW-1:0]   inner_start;
      logic [AW-1:0]   inner_end;
      logic [AW-1:0]   ign_addr;
      logic [IW-1:0]   ign_cnt;
      logic            ign_by_cnt;
      logic [CW-1:0]   page_size;
      logic [AW-1:0]   mem_ptr;
      logic [AW-1:0]   last_loaded;
      tvs_state_e      st;
      logic [AW-1:0]   pc;
      logic [AW-1:0]   outer_end;
      logic [AW-1:0]   outer_rem;
      logic [AW-1:0]   inner_rem;
      logic            free_run;
      logic            exit_pend;
      logic            suppress;
      logic            ign_active;
      logic            ign_cnt_mode;
      logic [IW-1:0]   ign_left;
      logic [1:0]      drain;
      logic [2:0]      stb;
      logic            vld;
      logic [NPIN-1:0] exp1;
      logic [NPIN-1:0] care1;
      logic [NPIN-1:0] exp2;
      logic [NPIN-1:0] care2;
      logic [NPIN-1:0] din1;
      logic [NPIN-1:0] din2;
      logic [NPIN-1:0] fail_res;
      logic            done;
      logic            failed;
   } tvs_state_s;

   tvs_state_s s;
   tvs_state_s next_s;
   logic [WW-1:0]   mem_rdata;
   logic            mem_we;
   logic            sel;
   logic            stb_now;
   logic            ign_now;
   logic            stop;
   logic [NPIN-1:0] mis;
   logic [AW-1:0]   wrap;
   logic [1:0]      chain;

   tvs_pattern_mem u_mem (
      .hclk  (hclk),
      .we    (mem_we),
      .waddr (s.mem_ptr),
      .wdata (hwdata[WW-1:0]),
      .raddr (s.pc),
      .rdata (mem_rdata)
   );

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign vec_drive = mem_rdata[NPIN-1:0];
   assign vec_valid = s.vld;
   assign busy = (s.st != ST_IDLE);
   assign done = s.done;
   assign failed = s.failed;
   assign sel = hsel & htrans[1] & hready;
   assign mem_we = s.wr_pend && (s.wr_idx == IDX_MEM_DATA);

   // Page size picks wrap point and chaining permission (bit 0 two-way, bit 1 four-way).
   always_comb
   begin
      if (s.page_size <= PAGE_1K)
      begin
         wrap = WRAP_1K; // RULE_16
         chain = 2'h3;
      end
      else if (s.page_size <= PAGE_2K)
      begin
         wrap = WRAP_2K; // RULE_16
         chain = 2'h1;
      end
      else
      begin
         wrap = WRAP_4K; // RULE_16
         chain = 2'h0;
      end
   end

   always_comb
   begin
      next_s = s;
      stop = 1'b0;
      ign_now = s.ign_active && (!s.ign_cnt_mode || (s.ign_left != '0));
      stb_now = 1'b0;
      mis = (s.din2 ^ s.exp2) & s.care2;
      // Response pins pass two flip-flops before the comparator sees them.
      next_s.din1 = dut_resp;
      next_s.din2 = s.din1;
      next_s.exp1 = mem_rdata[2*NPIN-1:NPIN];
      next_s.care1 = mem_rdata[WW-1:2*NPIN];
      next_s.exp2 = s.exp1;
      next_s.care2 = s.care1;
      next_s.stb = {s.stb[1:0], 1'b0};
      next_s.vld = (s.st == ST_RUN);

      if (s.st == ST_RUN)
      begin
         // Vectors inside a free-running inner loop are applied but never strobed.
         stb_now = !ign_now && !s.suppress
                   && !(s.free_run && (s.pc == s.inner_start)); // RULE_18 RULE_22
         next_s.stb[0] = stb_now;
         if (s.free_run && (s.pc == s.inner_start))
         begin
            next_s.suppress = 1'b1; // RULE_18
         end
         if (!s.ign_cnt_mode && (s.pc == s.ign_addr))
         begin
            next_s.ign_active = 1'b0; // RULE_09
         end
         if (s.ign_cnt_mode && (s.ign_left != '0))
         begin
            next_s.ign_left = s.ign_left - 1'b1; // RULE_10
         end
         if ((s.pc == s.inner_end) && s.free_run && !s.exit_pend)
         begin
            next_s.pc = s.inner_start; // RULE_18 RULE_19
         end
         else if ((s.pc == s.inner_end) && !s.free_run && (s.inner_rem != '0))
         begin
            next_s.inner_rem = s.inner_rem - 1'b1; // RULE_06
            next_s.pc = s.inner_start;
         end
         else if ((s.pc == s.inner_end) && s.free_run && (s.pc != s.outer_end))
         begin
            // First arrival after an exit request falls out of the loop.
            next_s.exit_pend = 1'b0; // RULE_20
            next_s.free_run = 1'b0;
            next_s.suppress = 1'b0;
            next_s.pc = s.pc + 1'b1; // RULE_20
         end
         else if ((s.pc == s.outer_end) && s.free_run && !s.exit_pend)
         begin
            next_s.pc = '0; // RULE_17
            next_s.suppress = 1'b0;
            next_s.inner_rem = (s.inner_cnt == '0) ? '0 : AW'(s.inner_cnt - 1'b1);
         end
         else if (s.pc == s.outer_end)
         begin
            // An exit with shared inner and outer end lands here as well.
            next_s.exit_pend = 1'b0; // RULE_21
            next_s.free_run = 1'b0;
            next_s.suppress = 1'b0;
            if (s.outer_rem != '0)
            begin
               next_s.outer_rem = s.outer_rem - 1'b1; // RULE_03 RULE_21
               next_s.pc = '0;
               next_s.inner_rem = (s.inner_cnt == '0) ? '0 : AW'(s.inner_cnt - 1'b1);
            end
            else
            begin
               stop = 1'b1; // RULE_05 RULE_14 RULE_21
            end
         end
         else if (s.pc == wrap)
         begin
            next_s.pc = '0; // RULE_15
         end
         else
         begin
            next_s.pc = s.pc + 1'b1; // RULE_14
         end
         if (stop)
         begin
            next_s.st = ST_DRAIN;
            next_s.drain = DRAIN_CYC - 1'b1;
         end
      end
      else if (s.st == ST_DRAIN)
      begin
         next_s.drain = s.drain - 1'b1;
      end

      // Comparison stage, three cycles behind the issued address.
      if (s.stb[2])
      begin
         if (s.sticky)
         begin
            next_s.fail_res = s.fail_res | mis; // RULE_12
         end
         else
         begin
            next_s.fail_res = mis; // RULE_13
            if (mis != '0)
            begin
               next_s.st = ST_IDLE; // RULE_23
               next_s.done = 1'b1;
               next_s.failed = 1'b1;
               next_s.stb = '0;
               next_s.vld = 1'b0;
               next_s.exit_pend = 1'b0;
               next_s.free_run = 1'b0;
            end
         end
      end
      if ((s.st == ST_DRAIN) && (s.drain == '0) && (next_s.st == ST_DRAIN))
      begin
         next_s.st = ST_IDLE; // RULE_23
         next_s.done = 1'b1;
         next_s.failed = (next_s.fail_res != '0);
      end

      // Bus address phase: capture write target, register read data.
      next_s.wr_pend = sel & hwrite;
      next_s.wr_idx = haddr[5:2];
      if (sel && !hwrite)
      begin
         unique case (haddr[5:2])
            IDX_CTRL: next_s.rdata = 32'({s.sticky, s.ign_opt, s.free_cfg, 2'h0});
            IDX_START: next_s.rdata = 32'(s.start_addr);
            IDX_OUTER: next_s.rdata = {4'h0, s.outer_end_cfg, 3'h0, s.outer_cnt};
            IDX_INNER_CNT: next_s.rdata = 32'(s.inner_cnt);
            IDX_INNER_BND: next_s.rdata = {4'h0, s.inner_end, 4'h0, s.inner_start};
            IDX_IGN_ADDR: next_s.rdata = 32'(s.ign_addr);
            IDX_IGN_CNT: next_s.rdata = {8'h0, s.ign_by_cnt, s.ign_cnt};
            IDX_PAGE: next_s.rdata = {2'h0, wrap, chain, 3'h0, s.page_size};
            IDX_STATUS: next_s.rdata = {4'h0, s.pc, 12'h0, s.free_run, s.failed, s.done,
                                        s.st != ST_IDLE};
            IDX_FAIL: next_s.rdata = 32'(s.fail_res);
            IDX_MEM_ADDR: next_s.rdata = {4'h0, s.last_loaded, 4'h0, s.mem_ptr};
            default: next_s.rdata = '0;
         endcase
      end

      // Bus data phase: register writes.
      if (s.wr_pend)
      begin
         unique case (s.wr_idx)
            IDX_CTRL:
            begin
               next_s.free_cfg = hwdata[CTRL_FREE];
               next_s.ign_opt = hwdata[CTRL_IGN];
               next_s.sticky = hwdata[CTRL_STICKY];
               if (hwdata[CTRL_EXIT] && s.free_run && (next_s.st == ST_RUN))
               begin
                  next_s.exit_pend = 1'b1; // RULE_20
               end
               if (hwdata[CTRL_START] && (s.st == ST_IDLE))
               begin
                  next_s.st = ST_RUN;
                  next_s.done = 1'b0;
                  next_s.failed = 1'b0;
                  next_s.fail_res = '0; // RULE_12
                  next_s.pc = s.start_set ? s.start_addr : '0; // RULE_01 RULE_02
                  next_s.start_set = 1'b0;
                  next_s.outer_set = 1'b0;
                  next_s.outer_end = s.outer_set ? s.outer_end_cfg : s.last_loaded; // RULE_04
                  next_s.outer_rem = (s.outer_set && (s.outer_cnt != '0))
                                     ? AW'(s.outer_cnt - 1'b1) : '0; // RULE_05
                  next_s.inner_rem = (s.inner_cnt == '0)
                                     ? '0 : AW'(s.inner_cnt - 1'b1); // RULE_07
                  next_s.free_run = hwdata[CTRL_FREE]; // RULE_17
                  next_s.exit_pend = 1'b0;
                  next_s.suppress = 1'b0;
                  next_s.ign_active = hwdata[CTRL_IGN]; // RULE_22
                  next_s.ign_cnt_mode = s.ign_by_cnt; // RULE_11
                  next_s.ign_left = s.ign_cnt; // RULE_10
               end
            end
            IDX_START:
            begin
               next_s.start_addr = hwdata[AW-1:0];
               next_s.start_set = 1'b1;
            end
            IDX_OUTER:
            begin
               next_s.outer_cnt = hwdata[CW-1:0]; // RULE_03
               next_s.outer_end_cfg = hwdata[HI_POS+AW-1:HI_POS];
               next_s.outer_set = 1'b1;
            end
            IDX_INNER_CNT: next_s.inner_cnt = hwdata[CW-1:0]; // RULE_08
            IDX_INNER_BND:
            begin
               next_s.inner_start = hwdata[AW-1:0]; // RULE_08
               next_s.inner_end = hwdata[HI_POS+AW-1:HI_POS];
            end
            IDX_IGN_ADDR:
            begin
               next_s.ign_addr = hwdata[AW-1:0];
               next_s.ign_by_cnt = 1'b0; // RULE_11
            end
            IDX_IGN_CNT:
            begin
               next_s.ign_cnt = hwdata[IW-1:0];
               next_s.ign_by_cnt = 1'b1; // RULE_11
            end
            IDX_PAGE: next_s.page_size = hwdata[CW-1:0];
            IDX_MEM_ADDR: next_s.mem_ptr = hwdata[AW-1:0];
            IDX_MEM_DATA:
            begin
               next_s.last_loaded = s.mem_ptr; // RULE_04
               next_s.mem_ptr = s.mem_ptr + 1'b1;
            end
            default: next_s.mem_ptr = s.mem_ptr;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.st <= ST_IDLE;
         s.outer_cnt <= RST_COUNT;
         s.inner_cnt <= RST_COUNT; // RULE_07
         s.page_size <= RST_PAGE;
      end
      else
      begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// >>> tb/tvs_dut_model.sv
`timescale 1ns/1ps
`default_nettype none
module tvs_dut_model
   import tvs_pkg::*;
(
   input  wire logic            hclk,      // clock
   input  wire logic [NPIN-1:0] vec_drive, // applied vector
   input  wire logic            vec_valid, // vector live
   input  wire logic [NPIN-1:0] bad_lo,    // lowest vector answered wrongly
   input  wire logic [NPIN-1:0] bad_hi,    // highest vector answered wrongly
   output logic      [NPIN-1:0] dut_resp   // response pins
);
   logic [NPIN-1:0] last_q;
   logic            bad;
   // Floating pins show the inverse of the last value, so a stale echo never matches.
   always_comb
   begin
      bad = (vec_drive >= bad_lo) && (vec_drive <= bad_hi);
      if (vec_valid)
         dut_resp = vec_drive ^ {{(NPIN-1){1'b0}}, bad};
      else
         dut_resp = ~last_q;
   end
   always_ff @(posedge hclk)
   begin
      last_q <= dut_resp;
   end
endmodule
`default_nettype wire

// >>> tb/tvs_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tvs_sequencer_chk
   import tvs_pkg::*;
(
   input wire logic        hclk,      // clock
   input wire logic        hresetn,   // reset, active low
   input wire logic        hsel,      // select
   input wire logic [1:0]  htrans,    // transfer type
   input wire logic        hwrite,    // write
   input wire logic        hready,    // bus ready
   input wire logic        hreadyout, // slave ready
   input wire logic        hresp,     // response
   input wire logic [31:0] hrdata,    // read data
   input wire logic        vec_valid, // vector live
   input wire logic        busy,      // running
   input wire logic        done,      // terminated
   input wire logic        failed     // outcome
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ready_high_a: assert property (hreadyout)
      else $error("hreadyout low");
   resp_okay_a: assert property (!hresp)
      else $error("hresp not okay");
   end_done_a: assert property ($fell(busy) |-> done)
      else $error("busy fell without done");
   valid_busy_a: assert property (vec_valid |-> busy)
      else $error("vector issued while idle");
   start_clear_a: assert property ($rose(busy) |-> !done)
      else $error("done not cleared at start");
   first_vec_a: assert property ($rose(busy) |-> !vec_valid ##1 vec_valid)
      else $error("first vector not one cycle after start");
   fail_at_end_a: assert property ($rose(failed) |-> $rose(done))
      else $error("failed rose apart from done");
   done_holds_a: assert property (done |=> done || busy)
      else $error("done dropped without a new run");
   rdata_hold_a: assert property ($changed(hrdata)
      |-> $past(hsel && htrans[1] && hready && !hwrite))
      else $error("hrdata changed without a read");
endmodule
bind tvs_sequencer tvs_sequencer_chk chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .hrdata, .vec_valid, .busy, .done, .failed);
`default_nettype wire

// >>> tb/tvs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tvs_sequencer_tb
   import tvs_pkg::*;
;
   logic            hclk = 1'b0;
   logic            hresetn = 1'b0;
   logic            hsel = 1'b0;
   logic [31:0]     haddr = 32'h0;
   logic [1:0]      htrans = 2'h0;
   logic            hwrite = 1'b0;
   logic [31:0]     hwdata = 32'h0;
   logic [NPIN-1:0] bad_lo = 8'hff;
   logic [NPIN-1:0] bad_hi = 8'h00;
   logic            hreadyout;
   logic            hresp;
   logic [31:0]     hrdata;
   logic [NPIN-1:0] vec_drive;
   logic            vec_valid;
   logic [NPIN-1:0] dut_resp;
   logic            busy;
   logic            done;
   logic            failed;
   logic [7:0]      vq[$];
   int              n_fail = 0;
   int              checks = 0;
   int              cycles = 0;
   logic [3:0]      ig_idx1[4] = '{IDX_IGN_ADDR, IDX_IGN_CNT, IDX_IGN_CNT, IDX_IGN_ADDR};
   logic [3:0]      ig_idx2[4] = '{IDX_IGN_CNT, IDX_IGN_ADDR, IDX_IGN_CNT, IDX_IGN_ADDR};
   logic [31:0]     ig_val1[4] = '{32'h1, 32'h3, 32'h3, 32'h1};
   logic [31:0]     ig_val2[4] = '{32'h3, 32'h1, 32'h2, 32'h2};
   logic            ig_fail[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

   tvs_sequencer dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .vec_drive, .vec_valid, .dut_resp,
      .busy, .done, .failed);
   tvs_dut_model dut_model_u (.hclk, .vec_drive, .vec_valid, .bad_lo, .bad_hi, .dut_resp);

   initial
   begin
      forever #25 hclk = ~hclk;
   end

   always @(posedge hclk)
   begin
      if (vec_valid === 1'b1)
         vq.push_back(vec_drive);
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // A hang in any run ends here rather than stalling the simulator.
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {26'h0, idx, 2'b00};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      bus(1'b1, idx, wd, rd);
   endtask

   task automatic rdchk(input string what, input logic [3:0] idx, input logic [31:0] mask,
                        input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, idx, 32'h0, rd);
      chk(what, exp, rd & mask);
   endtask

   // Each word expects back what it drives, with every pin cared for.
   task automatic load(input logic [11:0] at, input logic [7:0] d[$]);
      wr(IDX_MEM_ADDR, {20'h0, at});
      foreach (d[i]) wr(IDX_MEM_DATA, {8'h0, 8'hff, d[i], d[i]});
   endtask

   task automatic wait_done();
      @(posedge hclk);
      while (done !== 1'b1) @(posedge hclk);
   endtask

   task automatic run(input logic [31:0] ctrl);
      vq.delete();
      wr(IDX_CTRL, ctrl);
      wait_done();
   endtask

   task automatic cmpq(input logic [7:0] e[$], input bit tail);
      int off;
      off = tail ? vq.size() - e.size() : 0;
      if (!tail)
         chk("vector count", 32'(e.size()), 32'(vq.size()));
      foreach (e[i]) chk("vector", {24'h0, e[i]}, {24'h0, vq[off + i]});
   endtask

   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk("status", IDX_STATUS, 32'h7, 32'h0);
      rdchk("inner count", IDX_INNER_CNT, 32'h1fff, 32'h1);
      rdchk("page size", IDX_PAGE, 32'h1fff, 32'h1000);
      wr(4'hc, 32'hffff_ffff);
      rdchk("unmapped", 4'hc, 32'hffff_ffff, 32'h0);
      load(12'h0, '{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7});
      run(32'h1);
      cmpq('{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7}, 1'b0);
      chk("pass", 32'h0, {31'h0, failed});
      wr(IDX_START, 32'h3);
      wr(IDX_OUTER, 32'h0005_0002);
      wr(IDX_INNER_CNT, 32'h2);
      wr(IDX_INNER_BND, 32'h0002_0001);
      run(32'h1);
      cmpq('{8'h3, 8'h4, 8'h5, 8'h0, 8'h1, 8'h2, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5}, 1'b0);
      run(32'h1);
      cmpq('{8'h0, 8'h1, 8'h2, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7}, 1'b0);
      wr(IDX_INNER_CNT, 32'h1);
      bad_lo <= 8'h0;
      bad_hi <= 8'h0;
      run(32'h11);
      cmpq('{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7}, 1'b0);
      chk("sticky fail", 32'h1, {31'h0, failed});
      rdchk("fail result", IDX_FAIL, 32'hff, 32'h1);
      run(32'h1);
      chk("early stop", 32'h1, {31'h0, (vq.size() < 8)});
      chk("fail stop", 32'h1, {31'h0, failed});
      bad_hi <= 8'h2;
      for (int i = 0; i < 4; i++)
      begin
         wr(ig_idx1[i], ig_val1[i]);
         wr(ig_idx2[i], ig_val2[i]);
         run(32'h9);
         chk("ignore outcome", {31'h0, ig_fail[i]}, {31'h0, failed});
      end
      bad_lo <= 8'h1;
      wr(IDX_OUTER, 32'h0007_0001);
      wr(IDX_INNER_CNT, 32'h2);
      wr(IDX_START, 32'h3);
      vq.delete();
      wr(IDX_CTRL, 32'h5);
      repeat (30) @(posedge hclk);
      rdchk("free status", IDX_STATUS, 32'hf, 32'h9);
      chk("free entry", 32'h0700_0102, {vq[4], vq[5], vq[6], vq[7]});
      load(12'h5, '{8'h55});
      wr(IDX_CTRL, 32'h6);
      wait_done();
      cmpq('{8'h2, 8'h3, 8'h4, 8'h55, 8'h6, 8'h7}, 1'b1);
      chk("free pass", 32'h0, {31'h0, failed});
      bad_lo <= 8'hff;
      bad_hi <= 8'h0;
      wr(IDX_PAGE, 32'h400);
      rdchk("wrap point", IDX_PAGE, 32'h3fff_0000, 32'h0fff_0000);
      load(12'h3fe, '{8'hfe, 8'hff});
      wr(IDX_START, 32'h3fe);
      wr(IDX_OUTER, 32'h0001_0001);
      wr(IDX_INNER_CNT, 32'h1);
      run(32'h1);
      cmpq('{8'hfe, 8'hff, 8'h0, 8'h1}, 1'b0);
      // Shared inner and outer end: the exit pass branches to zero once more, then stops.
      wr(IDX_OUTER, 32'h0002_0002);
      vq.delete();
      wr(IDX_CTRL, 32'h5);
      repeat (10) @(posedge hclk);
      wr(IDX_CTRL, 32'h6);
      wait_done();
      cmpq('{8'h2, 8'h0, 8'h1, 8'h2}, 1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
